// ### hw/spare_bit_pkg.sv
// Constants, register map and reset values for the E1 spare-bit pattern block.
package spare_bit_pkg;

  localparam int          NUM_SPARE      = 5;
  localparam int          PAT_W          = 8;
  localparam int          FRAME_IDX_W    = 4;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 32;
  localparam int          STRB_W         = 4;

  // Word indices of the registers; the byte address is four times the index.
  localparam logic [5:0]  REG_IDX_TX4    = 6'h00;
  localparam logic [5:0]  REG_IDX_TX8    = 6'h04;
  localparam logic [5:0]  REG_IDX_RX4    = 6'h05;
  localparam logic [ADDR_W-1:0] ADDR_TX4 = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RX4 = 8'h14;

  localparam logic [PAT_W-1:0] TX_PAT_RESET = 8'hff;
  localparam logic [PAT_W-1:0] RX_CAP_RESET = 8'h00;

  // Frame index carries frame number minus one, so even frames have the LSB set.
  localparam logic        EVEN_FRAME_LSB = 1'b1;
  localparam logic [2:0]  PAT_MSB        = 3'h7;
  localparam logic [FRAME_IDX_W-1:0] IDX_FRAME2  = 4'h1;
  localparam logic [FRAME_IDX_W-1:0] IDX_FRAME16 = 4'hf;

endpackage

// ### hw/rx_spare4_assembler.sv
// Gathers received Sa4 bits over one multiframe and loads them at its end.
`timescale 1ns/1ns
module rx_spare4_assembler (
  input  wire logic                                    CLK,
  input  wire logic                                    SYS_RST,
  input  wire logic                                    bit_strobe,
  input  wire logic [spare_bit_pkg::FRAME_IDX_W-1:0]   frame_idx,
  input  wire logic                                    spare_bit,
  input  wire logic                                    mf_end,
  input  wire logic                                    link_enable,
  output logic      [spare_bit_pkg::PAT_W-1:0]         captured_bits
);
  import spare_bit_pkg::*;

  typedef struct packed {
    logic [PAT_W-1:0] shadow;
    logic [PAT_W-1:0] capture;
  } asm_s;

  asm_s st_q;
  asm_s st_d;

  // Even frames write their bit into the shadow; the visible copy changes only at
  // the multiframe end, so a read never mixes two multiframes.
  always_comb
  begin
    st_d = st_q;
    if (bit_strobe && frame_idx[0] == EVEN_FRAME_LSB)
    begin
      st_d.shadow[PAT_MSB - frame_idx[3:1]] = spare_bit;
    end
    if (mf_end && link_enable)
    begin
      st_d.capture = st_d.shadow;
    end
  end

  // State register.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_q.shadow  <= RX_CAP_RESET;
      st_q.capture <= RX_CAP_RESET;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign captured_bits = st_q.capture;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  chk_rx_hold_partway: assert property (!mf_end |=> $stable(st_q.capture))
    else $error("Receive capture changed outside a multiframe end.");
  chk_rx_frame2_msb: assert property (
    bit_strobe && frame_idx == IDX_FRAME2 |=> st_q.shadow[PAT_MSB] == $past(spare_bit))
    else $error("Frame 2 receive bit did not land in bit 7.");
  chk_rx_frame16_lsb: assert property (
    bit_strobe && frame_idx == IDX_FRAME16 |=> st_q.shadow[0] == $past(spare_bit))
    else $error("Frame 16 receive bit did not land in bit 0.");

endmodule // rx_spare4_assembler

// ### hw/spare_bit_regs.sv
// APB register block for transmit spare-bit patterns and the received Sa4 capture.
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ns
module spare_bit_regs (
  input  wire logic                                              CLK,
  input  wire logic                                              SYS_RST,
  input  wire logic                                              PSEL,
  input  wire logic                                              PENABLE,
  input  wire logic                                              PWRITE,
  input  wire logic [spare_bit_pkg::ADDR_W-1:0]                  PADDR,
  input  wire logic [spare_bit_pkg::DATA_W-1:0]                  PWDATA,
  input  wire logic [spare_bit_pkg::STRB_W-1:0]                  PSTRB,
  output logic      [spare_bit_pkg::DATA_W-1:0]                  PRDATA,
  output logic                                                   PREADY,
  output logic                                                   PSLVERR,
  input  wire logic [spare_bit_pkg::NUM_SPARE-1:0]               TX_LINK_ENABLE,
  input  wire logic [spare_bit_pkg::NUM_SPARE-1:0]               TX_FROM_REGISTER,
  input  wire logic [spare_bit_pkg::FRAME_IDX_W-1:0]             TX_FRAME_IDX,
  output logic      [spare_bit_pkg::NUM_SPARE-1:0]               TX_SPARE_BITS,
  output logic      [spare_bit_pkg::NUM_SPARE-1:0]               TX_SPARE_FROM_REG,
  input  wire logic                                              RX_SPARE4_LINK_ENABLE,
  input  wire logic                                              RX_SPARE4_STROBE,
  input  wire logic [spare_bit_pkg::FRAME_IDX_W-1:0]             RX_FRAME_IDX,
  input  wire logic                                              RX_SPARE4_BIT,
  input  wire logic                                              RX_MF_END
);
  import spare_bit_pkg::*;

  typedef logic [PAT_W-1:0] pat_t;

  typedef struct packed {
    pat_t [NUM_SPARE-1:0]  tx_pat;
    logic [DATA_W-1:0]     rdata;
    logic [NUM_SPARE-1:0]  tx_bits;
    logic [NUM_SPARE-1:0]  tx_src;
  } regs_s;

  regs_s                 st_q;
  regs_s                 st_d;
  logic  [PAT_W-1:0]     rx_captured;
  logic  [5:0]           word_idx;
  logic                  hit_tx;
  logic                  hit_rx;
  logic                  setup_ph;
  logic                  access_ph;
  logic                  wr_tx;
  logic  [2:0]           tx_sel;
  logic  [2:0]           tx_bit_pos;

  // The capture half runs in its own module so the shadow stays private.
  rx_spare4_assembler u_rx4 (
    .CLK           (CLK),
    .SYS_RST       (SYS_RST),
    .bit_strobe    (RX_SPARE4_STROBE),
    .frame_idx     (RX_FRAME_IDX),
    .spare_bit     (RX_SPARE4_BIT),
    .mf_end        (RX_MF_END),
    .link_enable   (RX_SPARE4_LINK_ENABLE),
    .captured_bits (rx_captured)
  );

  // Address decode; only the word index counts, the two low bits are ignored.
  assign word_idx   = PADDR[ADDR_W-1:2];
  assign hit_tx     = (word_idx >= REG_IDX_TX4) && (word_idx <= REG_IDX_TX8);
  assign hit_rx     = (word_idx == REG_IDX_RX4);
  assign setup_ph   = PSEL && !PENABLE;
  assign access_ph  = PSEL && PENABLE;
  assign tx_sel     = word_idx[2:0];
  assign tx_bit_pos = PAT_MSB - TX_FRAME_IDX[3:1];
  assign wr_tx      = access_ph && PWRITE && hit_tx && PSTRB[0];

  // Read data is latched in the setup cycle, so the access phase never waits and
  // PRDATA still comes straight from a flip-flop.
  assign PREADY  = 1'b1;
  // Unmapped words and writes to the read-only capture answer with an error.
  assign PSLVERR = access_ph && (!(hit_tx || hit_rx) || (hit_rx && PWRITE));

  // Next-state logic for the pattern registers, read data and transmit bits.
  always_comb
  begin
    st_d = st_q;
    if (setup_ph)
    begin
      st_d.rdata = '0;
      if (hit_tx)
      begin
        st_d.rdata[PAT_W-1:0] = st_q.tx_pat[tx_sel];
      end
      else if (hit_rx && RX_SPARE4_LINK_ENABLE)
      begin
        st_d.rdata[PAT_W-1:0] = rx_captured;
      end
    end
    if (wr_tx)
    begin
      st_d.tx_pat[tx_sel] = PWDATA[PAT_W-1:0];
    end
    // One pass per spare position: select the bit for this frame and flag
    // whether the framer should insert it from the register.
    for (int k = 0; k < NUM_SPARE; k++)
    begin
      st_d.tx_bits[k] = st_q.tx_pat[k][tx_bit_pos];
      st_d.tx_src[k]  = TX_LINK_ENABLE[k] && TX_FROM_REGISTER[k];
    end
  end

  // State register; patterns come up as all ones so an idle line sends ones.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      st_q.tx_pat  <= {NUM_SPARE{TX_PAT_RESET}};
      st_q.rdata   <= '0;
      st_q.tx_bits <= '0;
      st_q.tx_src  <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign PRDATA            = st_q.rdata;
  assign TX_SPARE_BITS     = st_q.tx_bits;
  assign TX_SPARE_FROM_REG = st_q.tx_src;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // A bus write to a given word: setup, then the access edge.
  sequence s_apb_write(logic [5:0] idx);
    setup_ph && PWRITE && word_idx == idx ##1 access_ph && PWRITE && PREADY;
  endsequence

  // A bus read: setup, then the access edge.
  sequence s_apb_read(logic [5:0] idx);
    setup_ph && !PWRITE && word_idx == idx ##1 access_ph && PREADY;
  endsequence

  chk_tx_reset_ones: assert property (
    $fell(SYS_RST) |-> st_q.tx_pat == {NUM_SPARE{TX_PAT_RESET}})
    else $error("Transmit patterns not all ones after reset.");
  // The master leaves exactly one idle cycle between the write and the readback.
  chk_tx_write_readback: assert property (
    s_apb_write(REG_IDX_TX4) ##0 PSTRB[0] ##1 !PSEL ##1 s_apb_read(REG_IDX_TX4)
      |-> PRDATA[PAT_W-1:0] == $past(PWDATA[PAT_W-1:0], 3))
    else $error("Transmit pattern did not read back the written value.");
  chk_tx_source_gate: assert property (
    ##1 TX_SPARE_FROM_REG == $past(TX_LINK_ENABLE & TX_FROM_REGISTER))
    else $error("Register source flag does not follow enable and select.");
  chk_tx_frame2_msb: assert property (
    TX_FRAME_IDX == IDX_FRAME2 |=> TX_SPARE_BITS[0] == $past(st_q.tx_pat[0][PAT_MSB]))
    else $error("Frame 2 did not send pattern bit 7.");
  chk_tx_frame16_lsb: assert property (
    TX_FRAME_IDX == IDX_FRAME16 |=> TX_SPARE_BITS[4] == $past(st_q.tx_pat[4][0]))
    else $error("Frame 16 did not send pattern bit 0.");
  chk_rx_write_ignored: assert property (
    access_ph && PWRITE && hit_rx && !(RX_MF_END && RX_SPARE4_LINK_ENABLE)
      |-> PSLVERR ##1 $stable(rx_captured))
    else $error("Write to the receive capture was not refused.");
  chk_rx_disabled_zero: assert property (
    s_apb_read(REG_IDX_RX4) ##0 !$past(RX_SPARE4_LINK_ENABLE) |-> PRDATA == '0)
    else $error("Receive capture visible while its link is disabled.");
  chk_rx_reset_zero: assert property (
    $fell(SYS_RST) |-> rx_captured == RX_CAP_RESET)
    else $error("Receive capture not zero after reset.");
  // A read set up two cycles after the load edge must see the fresh capture.
  chk_rx_mf_load: assert property (
    RX_MF_END && RX_SPARE4_LINK_ENABLE ##2 s_apb_read(REG_IDX_RX4)
      ##0 $past(RX_SPARE4_LINK_ENABLE) |-> PRDATA[PAT_W-1:0] == rx_captured)
    else $error("Read after multiframe end did not return the capture.");
  chk_apb_unmapped: assert property (
    access_ph && word_idx > REG_IDX_RX4 |-> PSLVERR && PREADY)
    else $error("Unmapped address did not answer with an error.");

  // Each register lives in the low byte, so the upper read bits never carry data.
  chk_prdata_upper: assert property (
    PRDATA[DATA_W-1:PAT_W] == '0)
    else $error("Read data carried bits above the register byte.");
  // An error answer outside an access phase would confuse the master.
  chk_pslverr_idle: assert property (
    !access_ph |-> !PSLVERR)
    else $error("Error answer raised outside an access phase.");
  // Patterns change only on a strobed write that hits a transmit word.
  chk_tx_pat_hold: assert property (
    !wr_tx |=> $stable(st_q.tx_pat))
    else $error("Transmit pattern changed without a write.");
  chk_tx_write_lands: assert property (
    wr_tx |=> st_q.tx_pat[$past(tx_sel)] == $past(PWDATA[PAT_W-1:0]))
    else $error("Transmit pattern write did not land.");
  // With the link enabled a read returns the capture as it stood at setup.
  chk_rx_read_enabled: assert property (
    s_apb_read(REG_IDX_RX4) ##0 $past(RX_SPARE4_LINK_ENABLE)
      |-> PRDATA[PAT_W-1:0] == $past(rx_captured))
    else $error("Enabled read did not return the receive capture.");
  // A multiframe end with the link disabled must leave the capture alone.
  chk_rx_load_gated: assert property (
    RX_MF_END && !RX_SPARE4_LINK_ENABLE |=> $stable(rx_captured))
    else $error("Receive capture loaded while its link was disabled.");

endmodule // spare_bit_regs

// ### verification/e1_line_model.sv
// Far-end E1 line model: frame counter and received Sa4 stream.
`timescale 1ns/1ns
module e1_line_model (
  input  wire logic                                  CLK,
  input  wire logic                                  SYS_RST,
  input  wire logic [spare_bit_pkg::PAT_W-1:0]       rx_pattern,
  output logic      [spare_bit_pkg::FRAME_IDX_W-1:0] frame_idx,
  output logic                                       rx_strobe,
  output logic                                       rx_bit,
  output logic                                       mf_end
);
  import spare_bit_pkg::*;
  logic [FRAME_IDX_W-1:0] idx_q;
  // Frames advance every clock, so multiframes arrive back to back.
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
      idx_q <= '0;
    else
      idx_q <= idx_q + 4'h1;
  end
  // Odd frames carry a wrong bit, so a design that takes them is caught.
  always_comb
  begin
    frame_idx = idx_q;
    rx_strobe = 1'b1;
    rx_bit    = idx_q[0] ? rx_pattern[3'h7 - idx_q[3:1]] : ~rx_pattern[0];
    mf_end    = (idx_q == 4'hf);
  end
endmodule // e1_line_model

// ### verification/tb_spare_bit_regs.sv
// Self-checking bench for the spare-bit pattern registers.
`timescale 1ns/1ns
module tb_spare_bit_regs;
  import spare_bit_pkg::*;
  logic                   clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic                   rx_en, strobe, rx_bit, mf_end;
  logic [ADDR_W-1:0]      paddr;
  logic [DATA_W-1:0]      pwdata, prdata, rd;
  logic [STRB_W-1:0]      pstrb;
  logic [NUM_SPARE-1:0]   tx_en, tx_sel, tx_bits, tx_reg;
  logic [FRAME_IDX_W-1:0] fidx;
  logic [PAT_W-1:0]       rx_pat;
  logic [PAT_W-1:0]       pat [NUM_SPARE];
  int                     err_count, checked;

  spare_bit_regs DUT (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TX_LINK_ENABLE(tx_en), .TX_FROM_REGISTER(tx_sel),
    .TX_FRAME_IDX(fidx), .TX_SPARE_BITS(tx_bits), .TX_SPARE_FROM_REG(tx_reg),
    .RX_SPARE4_LINK_ENABLE(rx_en), .RX_SPARE4_STROBE(strobe), .RX_FRAME_IDX(fidx),
    .RX_SPARE4_BIT(rx_bit), .RX_MF_END(mf_end));
  e1_line_model line (.CLK(clk), .SYS_RST(rst), .rx_pattern(rx_pat), .frame_idx(fidx),
    .rx_strobe(strobe), .rx_bit(rx_bit), .mf_end(mf_end));

  // Free-running 50 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input string name, input logic [DATA_W-1:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; it opens with an edge so back-to-back calls never collide.
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 16)
      err_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_mf;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (mf_end !== 1'b1 && n < 40);
    if (mf_end !== 1'b1)
      err_count++;
  endtask

  // Runs one multiframe and compares each even-frame bit of every position.
  task automatic tx_check(input logic [NUM_SPARE-1:0] en, sel);
    logic [FRAME_IDX_W-1:0] prev;
    tx_en <= en;
    tx_sel <= sel;
    repeat (2) @(posedge clk);
    chk("from register", tx_reg, en & sel);
    prev = fidx;
    repeat (16)
    begin
      @(posedge clk);
      if (prev[0])
        for (int k = 0; k < NUM_SPARE; k++)
          chk("spare bit", tx_bits[k], pat[k][3'h7 - prev[3:1]]);
      prev = fidx;
    end
  endtask

  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // The tests need about 150 cycles; 20000 leaves ample margin.
  initial
  begin
    #400000;
    err_count++;
    summarize;
  end

  initial
  begin
    {rst, psel, penable, pwrite, rx_en} = 5'h10;
    {paddr, pwdata, tx_en, tx_sel, rx_pat} = '0;
    pstrb = 4'hf;
    err_count = 0;
    checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      apb(1'b0, 8'(4 * i), '0);
      chk("reset value", rd, (i < 5) ? 32'hff : 32'h0);
      chk("read error", err, 1'b0);
    end
    // Writing the first word last puts a write right before its readback.
    for (int i = 4; i >= 0; i--)
    begin
      pat[i] = 8'h96 ^ 8'(i * 37);
      apb(1'b1, 8'(4 * i), {24'hffffff, pat[i]});
    end
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), '0);
      chk("pattern", rd, {24'h0, pat[i]});
    end
    pstrb <= 4'h0;
    apb(1'b1, ADDR_TX4, 32'h0);
    pstrb <= 4'hf;
    apb(1'b0, ADDR_TX4, '0);
    chk("masked write", rd, {24'h0, pat[0]});
    apb(1'b1, ADDR_RX4, 32'h5a);
    chk("capture write error", err, 1'b1);
    apb(1'b0, ADDR_RX4, '0);
    chk("capture after write", rd, 32'h0);
    apb(1'b0, 8'h18, '0);
    chk("unmapped error", err, 1'b1);
    tx_check(5'h1f, 5'h15);
    tx_check(5'h0e, 5'h1f);
    // Receive path: a read partway through a multiframe must see the old value.
    wait_mf;
    rx_en <= 1'b1;
    rx_pat <= 8'hb4;
    repeat (4) @(posedge clk);
    apb(1'b0, ADDR_RX4, '0);
    chk("partial capture", rd, 32'h0);
    wait_mf;
    rx_pat <= 8'h3c;
    apb(1'b0, ADDR_RX4, '0);
    chk("capture", rd, 32'hb4);
    rx_en <= 1'b0;
    apb(1'b0, ADDR_RX4, '0);
    chk("disabled capture", rd, 32'h0);
    wait_mf;
    rx_en <= 1'b1;
    apb(1'b0, ADDR_RX4, '0);
    chk("capture kept", rd, 32'hb4);
    summarize;
  end
endmodule // tb_spare_bit_regs
